//--- chan_exec.sv
/*
 channel processor execution unit for returns, held-block requeue, carry,
 shifts, send, sync search and store to main memory; apb register slave.
 assumes a single pclk domain, synchronous adapter and memory handshakes.
*/
// The APB slave port and the address map are this design's own decisions.
//  Function
// - branch return loads pc from link location
// - jump return: bump sp, pop pc, bump
// - held blocks requeued at next queue head
// - held return illegal unless configured enabled
// - valid, last block from control bit; clear last
// - carry clear and carry set ops
// - closed left: bit0 to carry, carry in
// - closed right: bit7 to carry, carry in
// - open left: bit0 to carry, zero fill
// - open right: bit7 to carry, zero fill
// - shifts set carry, top bit, zero
// - send copies result to line register
// - parity generated before crc accumulation
// - transmit underrun sets data services error
// - sync search cycles receiver off then on
// - sync declared after two sync characters
// - store writes result to memory at pointer
// - store decrements range, sets last at zero
`timescale 1ns/1ps
`include "chan_exec_defines.svh"
module chan_exec
	import chan_exec_pkg::*;
(
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// line adapter transmit side
	output logic      [7:0]  xmit_line_reg_one,
	output logic             xmit_load,
	output logic             xmit_crc_en,
	input  wire logic        xmit_underrun,
	// line adapter receiver control
	output logic             rcv_enable,
	input  wire logic        rcv_sync_char,
	output logic             rcv_in_sync,
	// host main memory byte write
	output logic      [23:0] mem_addr,
	output logic      [7:0]  mem_wdata,
	output logic             mem_wr,
	input  wire logic        mem_ack,
	// control block queue
	output logic             requeue_held,
	// program counter
	output logic      [7:0]  pc
);

	logic [7:0]  r_q, b_q, sp_q, pc_q, link_pc_q;
	logic        carry_q, top_q, zero_q, valid_q, lastb_q, lastc_q;
	logic        illegal_q, dse_q;
	logic [31:0] ccb_q;
	logic [23:0] ptr_q;
	logic [15:0] range_q;
	logic [31:0] cfg_q;
	logic [7:0]  stack_q [256];
	logic [7:0]  xmit_q;
	logic        xload_q, xcrc_q, rcv_en_q, insync_q, mwr_q, requeue_q;
	logic [1:0]  sync_cnt_q;
	logic [7:0]  crc_q;
	state_t      state_q;
	logic        go;
	op_t         op;
	logic        sel_b;
	logic [1:0]  send_mode;
	logic [7:0]  sh_val, sh_res;
	logic        sh_out;
	logic        is_shift;
	logic [7:0]  tx_char;

	wire wr_acc = psel & penable & pwrite;
	wire rd_acc = psel & penable & ~pwrite;

	function automatic logic mapped(input logic [11:0] a);
		mapped = (a <= `OFF_STACK) && (a[1:0] == 2'h0);
	endfunction : mapped

	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~mapped(paddr);

	// command word: [3:0] op, [4] b select, [6:5] send mode
	assign go        = wr_acc && paddr == `OFF_CMD && state_q == st_idle;
	assign op        = op_t'(pwdata[3:0]);
	assign sel_b     = pwdata[4];
	assign send_mode = pwdata[6:5];

	// bit 0 is the msb in program numbering, so bit 0 is sh_val[7]
	assign sh_val = sel_b ? b_q : r_q;
	always_comb begin
		sh_res   = sh_val;
		sh_out   = 1'b0;
		is_shift = 1'b1;
		case (op)
			rotate_left_through_carry: begin
				sh_res = {sh_val[6:0], carry_q};
				sh_out = sh_val[7];
			end
			rotate_right_through_carry: begin
				sh_res = {carry_q, sh_val[7:1]};
				sh_out = sh_val[0];
			end
			shift_left_zero_fill: begin
				sh_res = {sh_val[6:0], 1'b0};
				sh_out = sh_val[7];
			end
			shift_right_zero_fill: begin
				sh_res = {1'b0, sh_val[7:1]};
				sh_out = sh_val[0];
			end
			default: is_shift = 1'b0;
		endcase
	end

	// parity lands in the leftmost bit, which the program leaves zero
	assign tx_char = send_mode[0] ? {^r_q[6:0], r_q[6:0]} : r_q;

	// working registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r_q <= 8'h00;
			b_q <= 8'h00;
		end else if (go && is_shift) begin
			if (sel_b)
				b_q <= sh_res;
			else
				r_q <= sh_res;
		end else if (wr_acc && paddr == `OFF_REGS && state_q == st_idle) begin
			r_q <= pwdata[7:0];
			b_q <= pwdata[15:8];
		end
	end

	// indicators
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			carry_q <= 1'b0;
			top_q   <= 1'b0;
			zero_q  <= 1'b0;
			valid_q <= 1'b0;
			lastb_q <= 1'b0;
		end else if (go) begin
			if (is_shift) begin
				carry_q <= sh_out;
				top_q   <= sh_res[7];
				zero_q  <= (sh_res == 8'h00);
			end
			if (op == clear_carry_op)
				carry_q <= 1'b0;
			if (op == set_carry_op)
				carry_q <= 1'b1;
			if (op == return_held_blocks && cfg_q[`CFG_HELD_EN]) begin
				valid_q <= ccb_q[`CCB_CTRL_BIT];
				lastb_q <= ccb_q[`CCB_CTRL_BIT];
			end
		end
	end

	// last character flag: set by range reaching zero, cleared by requeue
	// range is looked at before the decrement, so one means the last byte
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			lastc_q <= 1'b0;
		else if (state_q == st_mem_wait && mem_ack && range_q == 16'h0001)
			lastc_q <= 1'b1;
		else if (go && op == return_held_blocks && cfg_q[`CFG_HELD_EN])
			lastc_q <= 1'b0;
	end

	// illegal and data services error are sticky; set wins over clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			illegal_q <= 1'b0;
			dse_q     <= 1'b0;
		end else begin
			if (go && op == return_held_blocks && !cfg_q[`CFG_HELD_EN])
				illegal_q <= 1'b1;
			else if (wr_acc && paddr == `OFF_FLAGS && pwdata[`FLG_ILLEGAL])
				illegal_q <= 1'b0;
			if (xload_q && xmit_underrun)
				dse_q <= 1'b1;
			else if (wr_acc && paddr == `OFF_FLAGS && pwdata[`FLG_DS_ERR])
				dse_q <= 1'b0;
		end
	end

	// config, link location and control block
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_q     <= 32'h0000_0000;
			link_pc_q <= 8'h00;
			ccb_q     <= 32'h0000_0000;
		end else if (wr_acc && state_q == st_idle) begin
			if (paddr == `OFF_CONFIG)
				cfg_q <= pwdata;
			if (paddr == `OFF_LINK_PC)
				link_pc_q <= pwdata[7:0];
			if (paddr == `OFF_CCB)
				ccb_q <= pwdata;
		end
	end

	// data pointer and byte range of the current control block
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ptr_q   <= 24'h00_0000;
			range_q <= 16'h0000;
		end else if (wr_acc && paddr == `OFF_CCB && state_q == st_idle) begin
			ptr_q   <= {8'h00, pwdata[15:0]};
			range_q <= {8'h00, pwdata[23:16]};
		end else if (state_q == st_mem_wait && mem_ack) begin
			ptr_q   <= ptr_q + 24'h00_0001;
			range_q <= range_q - 16'h0001;
		end
	end

	// stack memory; software may preload entries
	always_ff @(posedge pclk) begin
		if (wr_acc && paddr == `OFF_STACK && state_q == st_idle)
			stack_q[pwdata[15:8]] <= pwdata[7:0];
	end

	// sequencer, stack pointer and program counter
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= st_idle;
			sp_q    <= `SP_RESET;
			pc_q    <= `PC_RESET;
		end else begin
			case (state_q)
				st_idle: begin
					if (go) begin
						case (op)
							return_from_branch: pc_q <= link_pc_q;
							return_from_jump: begin
								sp_q    <= sp_q + 8'h01;
								state_q <= st_jump_fetch;
							end
							sync_search_op: state_q <= st_sync_off;
							store_main_op:  state_q <= st_mem_wait;
							default: pc_q <= pc_q + 8'h01;
						endcase
					end
				end
				st_jump_fetch: begin
					pc_q    <= stack_q[sp_q];
					state_q <= st_jump_bump;
				end
				st_jump_bump: begin
					sp_q    <= sp_q + 8'h01;
					state_q <= st_idle;
				end
				st_sync_off: state_q <= st_sync_on;
				st_sync_on: begin
					pc_q    <= pc_q + 8'h01;
					state_q <= st_idle;
				end
				st_mem_wait: begin
					if (mem_ack) begin
						pc_q    <= pc_q + 8'h01;
						state_q <= st_idle;
					end
				end
				default: state_q <= st_idle;
			endcase
		end
	end

	// transmit line register; crc runs over the char with parity
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			xmit_q  <= 8'h00;
			xload_q <= 1'b0;
			xcrc_q  <= 1'b0;
			crc_q   <= 8'h00;
		end else begin
			xload_q <= go && op == send_op;
			if (go && op == send_op) begin
				xmit_q <= tx_char;
				xcrc_q <= send_mode[1];
				if (send_mode[1])
					crc_q <= crc_q ^ tx_char;
			end
		end
	end

	// receiver control; the transmitter is untouched by a search
	// each cycle is one character slot: no sync strobe means another char
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rcv_en_q   <= 1'b1;
			insync_q   <= 1'b0;
			sync_cnt_q <= 2'h0;
		end else if (state_q == st_sync_off) begin
			rcv_en_q   <= 1'b0;
			insync_q   <= 1'b0;
			sync_cnt_q <= 2'h0;
		end else begin
			if (state_q == st_sync_on)
				rcv_en_q <= 1'b1;
			if (rcv_en_q && !insync_q) begin
				// a non-sync char breaks the pair, so counts stay consecutive
				if (!rcv_sync_char)
					sync_cnt_q <= 2'h0;
				else if (sync_cnt_q + 2'h1 == `SYNC_NEEDED)
					insync_q <= 1'b1;
				else
					sync_cnt_q <= sync_cnt_q + 2'h1;
			end
		end
	end

	// memory write and held-block requeue strobes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mwr_q     <= 1'b0;
			requeue_q <= 1'b0;
		end else begin
			mwr_q     <= go && op == store_main_op;
			requeue_q <= go && op == return_held_blocks
				&& cfg_q[`CFG_HELD_EN];
		end
	end

	// register read mux, registered so data is stable in the access phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			prdata <= 32'h0000_0000;
		else if (psel && !penable && !pwrite) begin
			case (paddr)
				`OFF_REGS:    prdata <= {8'h00, sp_q, b_q, r_q};
				`OFF_FLAGS:   prdata <= {23'h0, state_q != st_idle, dse_q,
					illegal_q, lastc_q, lastb_q, valid_q, zero_q, top_q,
					carry_q};
				`OFF_LINK_PC: prdata <= {16'h0000, pc_q, link_pc_q};
				`OFF_CCB:     prdata <= {range_q[7:0], ptr_q};
				`OFF_XMIT:    prdata <= {22'h0, insync_q, rcv_en_q, xmit_q};
				`OFF_CONFIG:  prdata <= cfg_q;
				`OFF_STACK:   prdata <= {24'h00_0000, crc_q};
				default:      prdata <= 32'h0000_0000;
			endcase
		end
	end

	assign xmit_line_reg_one = xmit_q;
	assign xmit_load         = xload_q;
	assign xmit_crc_en       = xcrc_q;
	assign rcv_enable        = rcv_en_q;
	assign rcv_in_sync       = insync_q;
	assign mem_addr          = ptr_q;
	assign mem_wdata         = r_q;
	// mwr_q covers the first cycle; the wait state holds it until ack
	assign mem_wr            = mwr_q | (state_q == st_mem_wait);
	assign requeue_held      = requeue_q;
	assign pc                = pc_q;

	wire unused = ^{rd_acc, pwdata[31:7]};
endmodule : chan_exec

//--- chan_exec_defines.svh
/*
 shared constants for the channel execution block: apb offsets, field
 positions, reset values, sync count; operation codes are in the package.
 assumes inclusion by bare name from the package and design file.
*/
`ifndef CHAN_EXEC_DEFINES_SVH
`define CHAN_EXEC_DEFINES_SVH

`define OFF_CMD        12'h000
`define OFF_REGS       12'h004
`define OFF_FLAGS      12'h008
`define OFF_LINK_PC    12'h00c
`define OFF_CCB        12'h010
`define OFF_XMIT       12'h014
`define OFF_CONFIG     12'h018
`define OFF_STACK      12'h01c

`define FLG_CARRY      0
`define FLG_TOP        1
`define FLG_ZERO       2
`define FLG_VALID      3
`define FLG_LAST_BLK   4
`define FLG_LAST_CHR   5
`define FLG_ILLEGAL    6
`define FLG_DS_ERR     7
`define FLG_BUSY       8

`define CFG_HELD_EN    0
`define CCB_CTRL_BIT   24
`define DS_ERR_BIT     2
`define LCT_RET_LOC    8'h12
`define LCT_DSE_LOC    8'h30

`define SP_RESET       8'hff
`define PC_RESET       8'h00
`define SYNC_NEEDED    2'h2

`endif

//--- chan_exec_pkg.sv
/*
 types for the channel execution block.
 assumes chan_exec_defines.svh is on the include path.
*/
package chan_exec_pkg;
	`include "chan_exec_defines.svh"

	typedef enum logic [3:0] {
		op_none,
		return_from_branch,
		return_from_jump,
		return_held_blocks,
		clear_carry_op,
		set_carry_op,
		rotate_left_through_carry,
		rotate_right_through_carry,
		shift_left_zero_fill,
		shift_right_zero_fill,
		send_op,
		sync_search_op,
		store_main_op
	} op_t;

	typedef enum logic [2:0] {
		st_idle,
		st_jump_fetch,
		st_jump_bump,
		st_sync_off,
		st_sync_on,
		st_mem_wait
	} state_t;
endpackage : chan_exec_pkg

//--- chan_exec_properties.sv
/*
 port checks for chan_exec.
 assumes a bind from the bench top file.
*/
`timescale 1ns/1ps
`include "chan_exec_defines.svh"
module chan_exec_properties
	import chan_exec_pkg::*;
(
	// clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// apb
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	// adapter, memory, queue
	input wire logic        xmit_load,
	input wire logic        rcv_enable,
	input wire logic        rcv_sync_char,
	input wire logic        rcv_in_sync,
	input wire logic [7:0]  mem_wdata,
	input wire logic        mem_wr,
	input wire logic        mem_ack,
	input wire logic        requeue_held
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic go, snd, syn, sto;
	// busy is not visible here, so commands are only issued when idle
	assign go  = psel && penable && pwrite && paddr == `OFF_CMD;
	assign snd = go && pwdata[3:0] == send_op;
	assign syn = go && pwdata[3:0] == sync_search_op;
	assign sto = go && pwdata[3:0] == store_main_op;
	a_send_loads: assert property (snd |=> xmit_load)
		else $error("send gave no load");
	a_load_pulse: assert property (xmit_load |=> !xmit_load)
		else $error("load longer than a cycle");
	a_sync_off: assert property (syn |-> ##2 !rcv_enable)
		else $error("receiver not switched off");
	a_sync_back: assert property ($fell(rcv_enable) |=> rcv_enable)
		else $error("receiver not switched on");
	a_sync_two: assert property (
		$rose(rcv_in_sync) |-> $past(rcv_sync_char)
			&& $past(rcv_sync_char, 2) && rcv_enable)
		else $error("sync declared without two sync chars");
	a_store_req: assert property (sto |=> mem_wr)
		else $error("store raised no write");
	a_store_hold: assert property (
		mem_wr && !mem_ack |=> mem_wr && $stable(mem_wdata))
		else $error("write dropped before ack");
	a_store_end: assert property (mem_wr && mem_ack |=> !mem_wr)
		else $error("write held after ack");
	a_requeue_pulse: assert property (requeue_held |=> !requeue_held)
		else $error("requeue longer than a cycle");
endmodule : chan_exec_properties

//--- chan_exec_partner.sv
/*
 far side model: line adapter and host memory byte port.
 assumes the bench sets ack delay, underrun and sync bursts.
*/
`timescale 1ns/1ps
module chan_exec_partner (
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// bench controls
	input  wire logic [3:0]  ack_delay,
	input  wire logic        underrun_on,
	input  wire logic        sync_go,
	input  wire logic [1:0]  sync_n,
	// design side
	input  wire logic        mem_wr,
	input  wire logic [23:0] mem_addr,
	input  wire logic [7:0]  mem_wdata,
	output logic             xmit_underrun,
	output logic             rcv_sync_char,
	output logic             mem_ack,
	output logic [23:0]      got_addr,
	output logic [7:0]       got_data
);
	logic [3:0] wait_q;
	logic [1:0] left_q;
	assign xmit_underrun = underrun_on;
	// memory answers slowly or at once, as the bench chooses
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wait_q   <= 4'h0;
			mem_ack  <= 1'b0;
			got_addr <= 24'h0;
			got_data <= 8'h0;
		end else begin
			mem_ack <= mem_wr && !mem_ack && wait_q == ack_delay;
			wait_q  <= (mem_wr && !mem_ack) ? wait_q + 4'h1 : 4'h0;
			if (mem_wr && mem_ack) begin
				got_addr <= mem_addr;
				got_data <= mem_wdata;
			end
		end
	end
	// sync chars back to back: a quiet cycle counts as another character
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			left_q        <= 2'h0;
			rcv_sync_char <= 1'b0;
		end else begin
			rcv_sync_char <= left_q != 2'h0;
			if (sync_go)
				left_q <= sync_n;
			else if (left_q != 2'h0)
				left_q <= left_q - 2'h1;
		end
	end
endmodule : chan_exec_partner

//--- chan_exec_bench.sv
/*
 self-checking bench for chan_exec over apb, with the partner model.
 assumes properties and partner files compile first.
*/
`timescale 1ns/1ps
`include "chan_exec_defines.svh"
module chan_exec_bench
	import chan_exec_pkg::*;
;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic        xmit_load, xmit_crc_en, xmit_underrun, rcv_enable, err;
	logic        rcv_sync_char, rcv_in_sync, mem_wr, mem_ack, b, c;
	logic        requeue_held, underrun_on, sync_go;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [7:0]  xmit_line_reg_one, mem_wdata, pc, got_data, v, e, f;
	logic [23:0] mem_addr, got_addr;
	logic [3:0]  ack_delay;
	logic [1:0]  sync_n, k;
	int          fails, checked, rq, i;

	chan_exec i_chan_exec (.*);
	chan_exec_partner i_chan_exec_partner (.*);

	initial pclk = 1'b0;
	always #5 pclk = ~pclk;
	always @(posedge pclk) if (requeue_held === 1'b1) rq++;

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	// release is followed by an idle edge so no signal is set twice
	task automatic apb(input logic w, input logic [11:0] a,
			input logic [31:0] d);
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	// leaves the flag word in rd once busy has cleared
	task automatic cmd(input logic [6:0] op);
		int n;
		n = 0;
		apb(1'b1, `OFF_CMD, {25'h0, op});
		apb(1'b0, `OFF_FLAGS, 32'h0);
		while (rd[`FLG_BUSY] !== 1'b0 && n < 200) begin
			n++;
			apb(1'b0, `OFF_FLAGS, 32'h0);
		end
		if (n == 200)
			fails++;
	endtask : cmd

	task automatic wrap_up();
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : wrap_up

	initial begin
		#100000;
		fails++;
		wrap_up();
	end

	initial begin
		{presetn, psel, penable, pwrite, sync_go, underrun_on} = 6'h0;
		{paddr, pwdata, ack_delay, sync_n} = 50'h0;
		fails = 0;
		checked = 0;
		rq = 0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, `OFF_REGS, 32'h0);
		chk(rd[23:16], 8'hff);
		for (i = 0; i < 16; i++) begin
			k = i[1:0];
			b = i[2];
			c = i[3];
			v = c ? 8'h96 : (k[0] ? 8'h01 : 8'h80);
			f = {7'h0, c & ~k[1]};
			e = k[0] ? {f[0], v[7:1]} : {v[6:0], f[0]};
			apb(1'b1, `OFF_REGS, b ? {16'h0, v, 8'h0} : {24'h0, v});
			cmd({3'h0, c ? set_carry_op : clear_carry_op});
			chk({7'h0, rd[0]}, {7'h0, c});
			cmd({2'h0, b, 4'h6 + {2'h0, k}});
			chk({5'h0, rd[2:0]},
				{5'h0, e == 8'h0, e[7], k[0] ? v[0] : v[7]});
			apb(1'b0, `OFF_REGS, 32'h0);
			chk(b ? rd[15:8] : rd[7:0], e);
		end
		apb(1'b1, `OFF_LINK_PC, 32'h5a);
		cmd({3'h0, return_from_branch});
		chk(pc, 8'h5a);
		apb(1'b1, `OFF_STACK, 32'h003c);
		apb(1'b1, `OFF_STACK, 32'h0177);
		cmd({3'h0, return_from_jump});
		chk(pc, 8'h3c);
		apb(1'b0, `OFF_REGS, 32'h0);
		chk(rd[23:16], 8'h01);
		apb(1'b1, `OFF_CCB, 32'h0102_1234);
		apb(1'b1, `OFF_REGS, 32'hc3);
		for (i = 0; i < 2; i++) begin
			ack_delay <= i ? 4'h0 : 4'h3;
			cmd({3'h0, store_main_op});
			chk(got_data, 8'hc3);
			chk(got_addr[7:0], 8'h34 + 8'(i));
			chk({7'h0, rd[`FLG_LAST_CHR]}, 8'(i));
		end
		apb(1'b0, `OFF_CCB, 32'h0);
		chk(rd[31:24], 8'h00);
		cmd({3'h0, return_held_blocks});
		chk({4'h0, rd[6:3]}, 8'h0c);
		apb(1'b1, `OFF_FLAGS, 32'h40);
		apb(1'b1, `OFF_CONFIG, 32'h1);
		cmd({3'h0, return_held_blocks});
		chk({4'h0, rd[6:3]}, 8'h03);
		chk(8'(rq), 8'h01);
		apb(1'b1, `OFF_REGS, 32'h34);
		for (i = 0; i < 4; i++) begin
			apb(1'b0, `OFF_STACK, 32'h0);
			v = rd[7:0];
			e = i[0] ? 8'hb4 : 8'h34;
			cmd({i[1:0], 1'b0, send_op});
			chk({7'h0, rd[`FLG_DS_ERR]}, 8'h00);
			chk(xmit_line_reg_one, e);
			chk({7'h0, xmit_crc_en}, {7'h0, i[1]});
			apb(1'b0, `OFF_STACK, 32'h0);
			chk(rd[7:0] ^ v, i[1] ? e : 8'h0);
		end
		underrun_on <= 1'b1;
		cmd({3'h0, send_op});
		chk({7'h0, rd[`FLG_DS_ERR]}, 8'h01);
		underrun_on <= 1'b0;
		for (i = 1; i < 3; i++) begin
			cmd({3'h0, sync_search_op});
			sync_n  <= 2'(i);
			sync_go <= 1'b1;
			@(posedge pclk);
			sync_go <= 1'b0;
			repeat (16) @(posedge pclk);
			apb(1'b0, `OFF_XMIT, 32'h0);
			chk({6'h0, rd[9:8]}, {6'h0, i == 2, 1'b1});
			chk(rd[7:0], 8'h34);
		end
		apb(1'b0, 12'h020, 32'h0);
		chk({7'h0, err}, 8'h01);
		wrap_up();
	end
endmodule : chan_exec_bench

bind chan_exec chan_exec_properties i_chan_exec_properties (.*);
